// [hw/olc_osc_ctrl.sv]
`include "olc_defs.svh"
module olc_osc_ctrl #(
	parameter int TMR_W = 16,
	parameter int WAKE_W = 4,
	parameter logic [3:0] LF_TRIM_RESET = `OLC_LF_TRIM_RST
) (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic CE_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	input wire logic [7:0] SFR_WDATA_I,
	output logic [7:0] SFR_RDATA_O,
	input wire logic [WAKE_W-1:0] WAKE_EVENT_I,
	input wire logic WAKE_TMR_TICK_I,
	input wire logic EXT_CLK_TICK_I,
	input wire logic LF_OSC_I,
	input wire logic TMR2_LFCAP_MODE_I,
	input wire logic TMR3_LFCAP_MODE_I,
	output logic SYSTEM_CLOCK_OUT_O,
	output logic HF_OSC_RUN_O,
	output logic LF_OSC_EN_O,
	output logic [3:0] LF_FREQ_TRIM_O,
	output logic WAKE_TIMER_SYNC_BUSY_O,
	output logic [TMR_W-1:0] TMR2_COUNT_O,
	output logic [TMR_W-1:0] TMR2_RELOAD_O,
	output logic TMR2_CAPTURE_O,
	output logic [TMR_W-1:0] TMR3_COUNT_O,
	output logic [TMR_W-1:0] TMR3_RELOAD_O,
	output logic TMR3_CAPTURE_O
);
	import olc_pkg::*;

	localparam logic [7:0] HF_LAST = 8'(`OLC_HF_SETTLE_CYC - 1);
	localparam logic [7:0] LF_LAST = 8'(`OLC_LF_SETTLE_CYC - 1);

	// register state
	logic hf_en_reg;
	logic hf_en_next;
	logic [1:0] hf_div_reg;
	logic [1:0] hf_div_next;
	olc_hf_state_t hf_state_reg;
	olc_hf_state_t hf_state_next;
	logic [7:0] hf_settle_reg;
	logic [7:0] hf_settle_next;
	logic [3:0] hf_cnt_reg;
	logic [3:0] hf_cnt_next;
	olc_sync_state_t sync_state_reg;
	olc_sync_state_t sync_state_next;
	logic [1:0] sync_cnt_reg;
	logic [1:0] sync_cnt_next;
	logic lf_en_reg;
	logic lf_en_next;
	logic [3:0] lf_trim_reg;
	logic [3:0] lf_trim_next;
	logic [1:0] lf_div_reg;
	logic [1:0] lf_div_next;
	logic lf_rdy_reg;
	logic lf_rdy_next;
	logic [7:0] lf_settle_reg;
	logic [7:0] lf_settle_next;
	olc_clksrc_t clksel_reg;
	olc_clksrc_t clksel_next;
	logic lf_div_prev_reg;
	logic system_clock_out_reg;
	logic system_clock_out_next;
	logic hf_run_reg;
	logic hf_run_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic wr_hf;
	logic wr_lf;
	logic wr_sel;
	logic hf_running;
	logic hf_ready;
	logic [3:0] hf_term;
	logic hf_div_tick;
	logic lf_gated;
	logic lf_div_level;
	logic wake_any;
	logic wake_nontimer;

	// write decode on the special function register bus
	assign wr_hf = SFR_WR_I && (SFR_ADDR_I == `OLC_ADDR_HF_CTRL);
	assign wr_lf = SFR_WR_I && (SFR_ADDR_I == `OLC_ADDR_LF_CTRL);
	assign wr_sel = SFR_WR_I && (SFR_ADDR_I == `OLC_ADDR_CLKSEL);

	// wake events arrive already qualified by their own sources
	assign wake_any = |WAKE_EVENT_I;
	assign wake_nontimer = |(WAKE_EVENT_I &
		~(WAKE_W'(1) << `OLC_WAKE_TMR_BIT));

	// high-frequency oscillator: enable, settle, suspend and wake
	always_comb begin
		hf_en_next = hf_en_reg;
		hf_div_next = hf_div_reg;
		hf_state_next = hf_state_reg;
		hf_settle_next = hf_settle_reg;
		if (wr_hf) begin
			hf_en_next = SFR_WDATA_I[`OLC_HF_EN_BIT];
			hf_div_next = SFR_WDATA_I[`OLC_HF_DIV_MSB:`OLC_HF_DIV_LSB];
		end
		case (hf_state_reg)
			OLC_HF_OFF: begin
				if (hf_en_next) begin
					hf_state_next = OLC_HF_SETTLE;
					hf_settle_next = 8'h00;
				end
			end
			OLC_HF_SETTLE: begin
				if (!hf_en_next) begin
					hf_state_next = OLC_HF_OFF;
				end else if (wr_hf && SFR_WDATA_I[`OLC_HF_SUSP_BIT]) begin
					hf_state_next = OLC_HF_SUSPEND;
				end else if (hf_settle_reg == HF_LAST) begin
					hf_state_next = OLC_HF_READY;
				end else begin
					hf_settle_next = hf_settle_reg + 8'h01;
				end
			end
			OLC_HF_READY: begin
				if (!hf_en_next) begin
					hf_state_next = OLC_HF_OFF;
				end else if (wr_hf && SFR_WDATA_I[`OLC_HF_SUSP_BIT]) begin
					hf_state_next = OLC_HF_SUSPEND;
				end
			end
			OLC_HF_SUSPEND: begin
				if (!hf_en_next) begin
					hf_state_next = OLC_HF_OFF;
				end else if (wake_any) begin
					// fast wake: no settle wait after suspend
					hf_state_next = OLC_HF_READY;
				end
			end
			default: hf_state_next = OLC_HF_OFF;
		endcase
	end

	assign hf_running = (hf_state_reg == OLC_HF_SETTLE) ||
		(hf_state_reg == OLC_HF_READY);
	assign hf_ready = (hf_state_reg == OLC_HF_READY);

	// high-frequency divider; counter freezes while suspended
	always_comb begin
		case (hf_div_reg)
			`OLC_HF_DIV_16: hf_term = `OLC_HF_TERM_16;
			`OLC_HF_DIV_4: hf_term = `OLC_HF_TERM_4;
			`OLC_HF_DIV_8: hf_term = `OLC_HF_TERM_8;
			`OLC_HF_DIV_2: hf_term = `OLC_HF_TERM_2;
			default: hf_term = `OLC_HF_TERM_16;
		endcase
		hf_cnt_next = hf_cnt_reg;
		hf_div_tick = 1'b0;
		if (hf_running) begin
			if (hf_cnt_reg >= hf_term) begin
				hf_cnt_next = 4'h0;
				hf_div_tick = 1'b1;
			end else begin
				hf_cnt_next = hf_cnt_reg + 4'h1;
			end
		end
	end

	// wake timer sync flag; a non-timer wake while suspended restarts the count (set wins)
	always_comb begin
		sync_state_next = sync_state_reg;
		sync_cnt_next = sync_cnt_reg;
		if (hf_state_reg == OLC_HF_SUSPEND && hf_en_reg && wake_nontimer) begin
			sync_state_next = OLC_SYNC_BUSY;
			sync_cnt_next = 2'h0;
		end else begin
			case (sync_state_reg)
				OLC_SYNC_IDLE: sync_cnt_next = 2'h0;
				OLC_SYNC_BUSY: begin
					if (WAKE_TMR_TICK_I) begin
						if (sync_cnt_reg == `OLC_SYNC_TICKS - 2'h1) begin
							sync_state_next = OLC_SYNC_IDLE;
							sync_cnt_next = 2'h0;
						end else begin
							sync_cnt_next = sync_cnt_reg + 2'h1;
						end
					end
				end
				default: sync_state_next = OLC_SYNC_IDLE;
			endcase
		end
	end

	// low-frequency control; ready drops only on reset or divider change
	always_comb begin
		lf_en_next = lf_en_reg;
		lf_trim_next = lf_trim_reg;
		lf_div_next = lf_div_reg;
		lf_rdy_next = lf_rdy_reg;
		lf_settle_next = lf_settle_reg;
		if (wr_lf) begin
			lf_en_next = SFR_WDATA_I[`OLC_LF_EN_BIT];
			lf_trim_next =
				SFR_WDATA_I[`OLC_LF_TRIM_MSB:`OLC_LF_TRIM_LSB];
			lf_div_next = SFR_WDATA_I[`OLC_LF_DIV_MSB:`OLC_LF_DIV_LSB];
		end
		if (lf_div_next != lf_div_reg) begin
			lf_rdy_next = 1'b0;
			lf_settle_next = 8'h00;
		end else if (lf_en_reg && !lf_rdy_reg) begin
			if (lf_settle_reg == LF_LAST) begin
				lf_rdy_next = 1'b1;
			end else begin
				lf_settle_next = lf_settle_reg + 8'h01;
			end
		end
	end

	// clock select and system clock tick mux
	always_comb begin
		clksel_next = clksel_reg;
		if (wr_sel) begin
			clksel_next = olc_clksrc_t'(SFR_WDATA_I[`OLC_CLKSEL_MSB:0]);
		end
		case (clksel_reg)
			OLC_SRC_HF_DIV: system_clock_out_next = hf_div_tick;
			OLC_SRC_EXT: system_clock_out_next = EXT_CLK_TICK_I;
			OLC_SRC_LF: system_clock_out_next = lf_div_level && !lf_div_prev_reg;
			OLC_SRC_HF_DIRECT: system_clock_out_next = hf_running;
			OLC_SRC_LOW_POWER: system_clock_out_next = 1'b1;
			default: system_clock_out_next = 1'b0; // reserved codes stop the clock
		endcase
		hf_run_next = (hf_state_next == OLC_HF_SETTLE) ||
			(hf_state_next == OLC_HF_READY);
	end

	// read data is registered on the read strobe
	always_comb begin
		rdata_next = rdata_reg;
		if (SFR_RD_I) begin
			case (SFR_ADDR_I)
				`OLC_ADDR_HF_CTRL: rdata_next = {hf_en_reg, hf_ready,
					hf_state_reg == OLC_HF_SUSPEND,
					sync_state_reg == OLC_SYNC_BUSY,
					`OLC_UNUSED_2B, hf_div_reg};
				`OLC_ADDR_LF_CTRL: rdata_next = {lf_en_reg, lf_rdy_reg,
					lf_trim_reg, lf_div_reg};
				`OLC_ADDR_CLKSEL: rdata_next = {`OLC_CLKSEL_PAD, clksel_reg};
				default: rdata_next = `OLC_UNMAPPED;
			endcase
		end
	end

	// all state registers; clock enable freezes everything
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			hf_en_reg <= `OLC_HF_EN_RST;
			hf_div_reg <= `OLC_HF_DIV_RST;
			hf_state_reg <= OLC_HF_READY;
			hf_settle_reg <= 8'h00;
			hf_cnt_reg <= 4'h0;
			sync_state_reg <= OLC_SYNC_IDLE;
			sync_cnt_reg <= 2'h0;
			lf_en_reg <= `OLC_LF_EN_RST;
			lf_trim_reg <= LF_TRIM_RESET;
			lf_div_reg <= `OLC_LF_DIV_RST;
			lf_rdy_reg <= 1'b0;
			lf_settle_reg <= 8'h00;
			clksel_reg <= OLC_SRC_HF_DIV;
			lf_div_prev_reg <= 1'b0;
			system_clock_out_reg <= 1'b0;
			hf_run_reg <= 1'b1;
			rdata_reg <= `OLC_RDATA_RST;
		end else if (CE_I) begin
			hf_en_reg <= hf_en_next;
			hf_div_reg <= hf_div_next;
			hf_state_reg <= hf_state_next;
			hf_settle_reg <= hf_settle_next;
			hf_cnt_reg <= hf_cnt_next;
			sync_state_reg <= sync_state_next;
			sync_cnt_reg <= sync_cnt_next;
			lf_en_reg <= lf_en_next;
			lf_trim_reg <= lf_trim_next;
			lf_div_reg <= lf_div_next;
			lf_rdy_reg <= lf_rdy_next;
			lf_settle_reg <= lf_settle_next;
			clksel_reg <= clksel_next;
			lf_div_prev_reg <= lf_div_level;
			system_clock_out_reg <= system_clock_out_next;
			hf_run_reg <= hf_run_next;
			rdata_reg <= rdata_next;
		end
	end

	// a disabled low-frequency oscillator shows a flat level
	assign lf_gated = LF_OSC_I && lf_en_reg;

	olc_lf_div u_lf_div (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.ce_i(CE_I),
		.lf_i(lf_gated),
		.sel_i(lf_div_reg),
		.lf_div_o(lf_div_level)
	);

	// timer 2 samples on falling, timer 3 on rising edges
	olc_tmr_cap #(
		.CNT_W(TMR_W),
		.CAPTURE_ON_RISE(1'b0)
	) u_tmr2 (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.ce_i(CE_I),
		.cap_mode_i(TMR2_LFCAP_MODE_I),
		.lf_i(lf_div_level),
		.count_o(TMR2_COUNT_O),
		.reload_o(TMR2_RELOAD_O),
		.capture_o(TMR2_CAPTURE_O)
	);

	olc_tmr_cap #(
		.CNT_W(TMR_W),
		.CAPTURE_ON_RISE(1'b1)
	) u_tmr3 (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.ce_i(CE_I),
		.cap_mode_i(TMR3_LFCAP_MODE_I),
		.lf_i(lf_div_level),
		.count_o(TMR3_COUNT_O),
		.reload_o(TMR3_RELOAD_O),
		.capture_o(TMR3_CAPTURE_O)
	);

	assign SFR_RDATA_O = rdata_reg;
	assign SYSTEM_CLOCK_OUT_O = system_clock_out_reg;
	assign HF_OSC_RUN_O = hf_run_reg;
	assign LF_OSC_EN_O = lf_en_reg;
	assign LF_FREQ_TRIM_O = lf_trim_reg;
	assign WAKE_TIMER_SYNC_BUSY_O = (sync_state_reg == OLC_SYNC_BUSY);
endmodule : olc_osc_ctrl

// [hw/olc_defs.svh]
`ifndef OLC_DEFS_SVH
`define OLC_DEFS_SVH

// register offsets on the special function register bus
`define OLC_ADDR_CLKSEL 8'ha9
`define OLC_ADDR_HF_CTRL 8'hb2
`define OLC_ADDR_LF_CTRL 8'he3

// field positions
`define OLC_HF_EN_BIT 7
`define OLC_HF_SUSP_BIT 5
`define OLC_HF_DIV_MSB 1
`define OLC_HF_DIV_LSB 0
`define OLC_LF_EN_BIT 7
`define OLC_LF_TRIM_MSB 5
`define OLC_LF_TRIM_LSB 2
`define OLC_LF_DIV_MSB 1
`define OLC_LF_DIV_LSB 0
`define OLC_CLKSEL_MSB 2
`define OLC_WAKE_TMR_BIT 3

// reset values and read-back fill values
`define OLC_HF_EN_RST 1'b1
`define OLC_HF_DIV_RST 2'h0
`define OLC_LF_EN_RST 1'b0
`define OLC_LF_DIV_RST 2'h0
`define OLC_LF_TRIM_RST 4'h8
`define OLC_RDATA_RST 8'h00
`define OLC_UNUSED_2B 2'h0
`define OLC_UNMAPPED 8'h00
`define OLC_CLKSEL_PAD 5'h00

// high-frequency divider codes and terminal counts
`define OLC_HF_DIV_16 2'h0
`define OLC_HF_DIV_4 2'h1
`define OLC_HF_DIV_8 2'h2
`define OLC_HF_DIV_2 2'h3
`define OLC_HF_TERM_16 4'hf
`define OLC_HF_TERM_8 4'h7
`define OLC_HF_TERM_4 4'h3
`define OLC_HF_TERM_2 4'h1

// low-frequency divider codes
`define OLC_LF_DIV_8 2'h0
`define OLC_LF_DIV_4 2'h1
`define OLC_LF_DIV_2 2'h2
`define OLC_LF_DIV_1 2'h3

// wake timer clocks that the sync flag may stay busy
`define OLC_SYNC_TICKS 2'h3

// timing
`define OLC_CLK_PERIOD_NS 10
`define OLC_HF_SETTLE_NS 100
`define OLC_LF_SETTLE_NS 1000
`define OLC_HF_SETTLE_CYC \
	((`OLC_HF_SETTLE_NS + `OLC_CLK_PERIOD_NS - 1) / `OLC_CLK_PERIOD_NS)
`define OLC_LF_SETTLE_CYC \
	((`OLC_LF_SETTLE_NS + `OLC_CLK_PERIOD_NS - 1) / `OLC_CLK_PERIOD_NS)

`endif

// [hw/olc_pkg.sv]
package olc_pkg;
	typedef enum logic [2:0] {
		OLC_SRC_HF_DIV = 3'h0,
		OLC_SRC_EXT = 3'h1,
		OLC_SRC_LF = 3'h2,
		OLC_SRC_HF_DIRECT = 3'h3,
		OLC_SRC_RSV4 = 3'h4,
		OLC_SRC_LOW_POWER = 3'h5,
		OLC_SRC_RSV6 = 3'h6,
		OLC_SRC_RSV7 = 3'h7
	} olc_clksrc_t;

	typedef enum logic [1:0] {
		OLC_HF_OFF = 2'h0,
		OLC_HF_SETTLE = 2'h1,
		OLC_HF_READY = 2'h2,
		OLC_HF_SUSPEND = 2'h3
	} olc_hf_state_t;

	typedef enum logic [0:0] {
		OLC_SYNC_IDLE = 1'h0,
		OLC_SYNC_BUSY = 1'h1
	} olc_sync_state_t;
endpackage : olc_pkg

// [hw/olc_lf_div.sv]
`include "olc_defs.svh"
module olc_lf_div (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic lf_i,
	input wire logic [1:0] sel_i,
	output logic lf_div_o
);
	import olc_pkg::*;

	logic lf_prev_reg;
	logic lf_prev_next;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic out_reg;
	logic out_next;

	// ripple of rising edges; each count bit halves the rate once more
	always_comb begin
		lf_prev_next = lf_i;
		cnt_next = cnt_reg;
		if (lf_i && !lf_prev_reg) begin
			cnt_next = cnt_reg + 3'h1;
		end
		case (sel_i)
			`OLC_LF_DIV_8: out_next = cnt_reg[2];
			`OLC_LF_DIV_4: out_next = cnt_reg[1];
			`OLC_LF_DIV_2: out_next = cnt_reg[0];
			`OLC_LF_DIV_1: out_next = lf_i;
			default: out_next = lf_i;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lf_prev_reg <= 1'b0;
			cnt_reg <= 3'h0;
			out_reg <= 1'b0;
		end else if (ce_i) begin
			lf_prev_reg <= lf_prev_next;
			cnt_reg <= cnt_next;
			out_reg <= out_next;
		end
	end

	assign lf_div_o = out_reg;
endmodule : olc_lf_div

// [hw/olc_tmr_cap.sv]
`include "olc_defs.svh"
module olc_tmr_cap #(
	parameter int CNT_W = 16,
	parameter bit CAPTURE_ON_RISE = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cap_mode_i,
	input wire logic lf_i,
	output logic [CNT_W-1:0] count_o,
	output logic [CNT_W-1:0] reload_o,
	output logic capture_o
);
	import olc_pkg::*;

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic [CNT_W-1:0] reload_reg;
	logic [CNT_W-1:0] reload_next;
	logic cap_reg;
	logic cap_next;
	logic lf_prev_reg;
	logic edge_hit;

	// free-running count on the system clock is the known time base
	always_comb begin
		edge_hit = CAPTURE_ON_RISE ? (lf_i && !lf_prev_reg)
			: (!lf_i && lf_prev_reg);
		count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		reload_next = reload_reg;
		cap_next = 1'b0;
		if (cap_mode_i && edge_hit) begin
			reload_next = count_reg;
			cap_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_reg <= '0;
			reload_reg <= '0;
			cap_reg <= 1'b0;
			lf_prev_reg <= 1'b0;
		end else if (ce_i) begin
			count_reg <= count_next;
			reload_reg <= reload_next;
			cap_reg <= cap_next;
			lf_prev_reg <= lf_i;
		end
	end

	assign count_o = count_reg;
	assign reload_o = reload_reg;
	assign capture_o = cap_reg;
endmodule : olc_tmr_cap

// [verif/olc_osc_ctrl_sva.sv]
module olc_osc_ctrl_sva #(
	parameter int TMR_W = 16,
	parameter int WAKE_W = 4
) (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic CE_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	input wire logic [7:0] SFR_WDATA_I,
	input wire logic [7:0] SFR_RDATA_O,
	input wire logic [WAKE_W-1:0] WAKE_EVENT_I,
	input wire logic WAKE_TMR_TICK_I,
	input wire logic HF_OSC_RUN_O,
	input wire logic [3:0] LF_FREQ_TRIM_O,
	input wire logic WAKE_TIMER_SYNC_BUSY_O,
	input wire logic TMR2_LFCAP_MODE_I,
	input wire logic TMR3_LFCAP_MODE_I,
	input wire logic [TMR_W-1:0] TMR2_RELOAD_O,
	input wire logic TMR2_CAPTURE_O,
	input wire logic TMR3_CAPTURE_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	logic [2:0] tick_reg;
	logic [2:0] tick_next;
	logic hf_wr;
	assign hf_wr = SFR_WR_I && CE_I && SFR_ADDR_I == 8'hb2;
	// ticks seen since busy began; a fresh non-timer wake restarts it
	always_comb begin
		tick_next = tick_reg;
		if (!WAKE_TIMER_SYNC_BUSY_O || |WAKE_EVENT_I[WAKE_W-2:0]) begin
			tick_next = 3'h0;
		end else if (WAKE_TMR_TICK_I && tick_reg != 3'h7) begin
			tick_next = tick_reg + 3'h1;
		end
	end
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			tick_reg <= 3'h0;
		end else begin
			tick_reg <= tick_next;
		end
	end
	a_rsv_zero: assert property ($past(SFR_RD_I && CE_I && SFR_ADDR_I == 8'hb2)
		|-> SFR_RDATA_O[3:2] == 2'h0) else $error("reserved bits read nonzero");
	a_off_stops: assert property (hf_wr && !SFR_WDATA_I[7]
		|-> ##[1:2] !HF_OSC_RUN_O) else $error("oscillator still running");
	a_susp_stops: assert property (hf_wr && SFR_WDATA_I[7] && SFR_WDATA_I[5]
		&& HF_OSC_RUN_O |-> ##[1:2] !HF_OSC_RUN_O) else $error("no suspend");
	a_ready_off: assert property (hf_wr && !SFR_WDATA_I[7] ##2
		(SFR_RD_I && SFR_ADDR_I == 8'hb2) |=> SFR_RDATA_O[7:6] == 2'h0)
		else $error("ready flag set while disabled");
	a_sync_cause: assert property ($rose(WAKE_TIMER_SYNC_BUSY_O)
		|-> $past(|WAKE_EVENT_I[WAKE_W-2:0]) ||
		$past(|WAKE_EVENT_I[WAKE_W-2:0], 2)) else $error("busy without wake");
	a_sync_bound: assert property (WAKE_TIMER_SYNC_BUSY_O |-> tick_reg <= 3'h3)
		else $error("busy beyond three timer clocks");
	a_trim_load: assert property (SFR_WR_I && CE_I && SFR_ADDR_I == 8'he3
		|=> ##1 LF_FREQ_TRIM_O == $past(SFR_WDATA_I[5:2], 2))
		else $error("trim not loaded");
	a_cap2_mode: assert property (!TMR2_LFCAP_MODE_I [*4] |-> !TMR2_CAPTURE_O)
		else $error("timer two captured outside mode");
	a_cap3_mode: assert property (!TMR3_LFCAP_MODE_I [*4] |-> !TMR3_CAPTURE_O)
		else $error("timer three captured outside mode");
	a_reload_hold: assert property ($changed(TMR2_RELOAD_O)
		|-> TMR2_CAPTURE_O || $past(TMR2_CAPTURE_O))
		else $error("reload changed without capture");
endmodule : olc_osc_ctrl_sva

// [verif/tb_top.sv]
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] wake = 4'h0;
	logic tick = 1'b0;
	logic lf = 1'b0;
	logic lf_on = 1'b0;
	logic ce = 1'b1;
	logic ext = 1'b0;
	logic [7:0] rdata;
	logic sys, run, lfen, busy, cap2, cap3;
	logic [3:0] trim;
	logic [15:0] cnt2, rl2, cnt3, rl3;
	int lf_cnt = 0;
	int cyc = 0;
	int err_count = 0;
	int total_checks = 0;
	olc_osc_ctrl dut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce),
		.SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata),
		.SFR_RDATA_O(rdata), .WAKE_EVENT_I(wake), .WAKE_TMR_TICK_I(tick),
		.EXT_CLK_TICK_I(ext), .LF_OSC_I(lf), .TMR2_LFCAP_MODE_I(lf_on),
		.TMR3_LFCAP_MODE_I(lf_on), .SYSTEM_CLOCK_OUT_O(sys),
		.HF_OSC_RUN_O(run), .LF_OSC_EN_O(lfen), .LF_FREQ_TRIM_O(trim),
		.WAKE_TIMER_SYNC_BUSY_O(busy), .TMR2_COUNT_O(cnt2),
		.TMR2_RELOAD_O(rl2), .TMR2_CAPTURE_O(cap2), .TMR3_COUNT_O(cnt3),
		.TMR3_RELOAD_O(rl3), .TMR3_CAPTURE_O(cap3));
	// clock and a free-running raw oscillator, 40 cycles a period;
	// the design gates it with its own enable bit
	initial forever #5 clk = ~clk;
	always @(negedge clk) begin
		lf_cnt = (lf_cnt + 1) % 20;
		if (lf_cnt == 0) lf <= ~lf;
	end
	// hang guard, well above the longest scenario
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(16'(rdata), 16'(exp));
	endtask : rd_reg
	// third gap between system clock pulses; early ones may be stale
	task automatic period(output logic [15:0] p);
		int n;
		repeat (3) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (sys !== 1'b1 && n < 100);
		end
		p = 16'(n);
	endtask : period
	task automatic t_reset();
		logic [15:0] c;
		rd_reg(8'hb2, 8'hc0);
		rd_reg(8'he3, 8'h20);
		rd_reg(8'ha9, 8'h00);
		wr_reg(8'h55, 8'hff);
		rd_reg(8'h55, 8'h00);
		rd_reg(8'hb2, 8'hc0);
		// a low clock enable freezes the timers and refuses writes
		c = cnt2;
		ce = 1'b0;
		wr_reg(8'hb2, 8'h00);
		chk(cnt2, c);
		ce = 1'b1;
		rd_reg(8'hb2, 8'hc0);
	endtask : t_reset
	task automatic t_hfdiv();
		logic [15:0] r [4] = '{16'h10, 16'h4, 16'h8, 16'h2};
		logic [15:0] p;
		for (int c = 0; c < 4; c++) begin
			wr_reg(8'hb2, 8'h8c | 8'(c));
			rd_reg(8'hb2, 8'hc0 | 8'(c));
			period(p);
			chk(p, r[c]);
		end
		// direct source ignores the divider; reserved source is silent
		wr_reg(8'ha9, 8'hfb);
		rd_reg(8'ha9, 8'h03);
		period(p);
		chk(p, 16'h1);
		wr_reg(8'ha9, 8'h04);
		period(p);
		chk(p, 16'h64);
		// external ticks and the low-power source bypass the divider too
		wr_reg(8'ha9, 8'h01);
		ext = 1'b1;
		period(p);
		chk(p, 16'h1);
		ext = 1'b0;
		wr_reg(8'ha9, 8'h05);
		period(p);
		chk(p, 16'h1);
		wr_reg(8'ha9, 8'h00);
	endtask : t_hfdiv
	task automatic t_enable();
		wr_reg(8'hb2, 8'h00);
		// read back at once so the ready-flag assertion sees the read
		chk(16'(run), 16'h0);
		rd_reg(8'hb2, 8'h00);
		wr_reg(8'hb2, 8'h80);
		rd_reg(8'hb2, 8'h80);
		repeat (12) @(negedge clk);
		rd_reg(8'hb2, 8'hc0);
		chk(16'(run), 16'h1);
	endtask : t_enable
	task automatic pulse(input logic [3:0] w, input int ticks);
		@(negedge clk);
		wake = w;
		@(negedge clk);
		wake = 4'h0;
		repeat (ticks) begin
			@(negedge clk);
			tick = 1'b1;
			@(negedge clk);
			tick = 1'b0;
			repeat (3) @(negedge clk);
		end
	endtask : pulse
	task automatic t_suspend();
		wr_reg(8'hb2, 8'ha3);
		repeat (2) @(negedge clk);
		chk(16'(run), 16'h0);
		pulse(4'h1, 0);
		repeat (2) @(negedge clk);
		chk(16'(run), 16'h1);
		chk(16'(busy), 16'h1);
		pulse(4'h0, 2);
		chk(16'(busy), 16'h1);
		pulse(4'h0, 1);
		chk(16'(busy), 16'h0);
		// timer wake needs no resync
		wr_reg(8'hb2, 8'ha3);
		repeat (2) @(negedge clk);
		pulse(4'h8, 0);
		repeat (2) @(negedge clk);
		chk(16'(run), 16'h1);
		chk(16'(busy), 16'h0);
	endtask : t_suspend
	// gap between the second and third captures of one timer
	task automatic cap_gap(input bit t3, input bit pol, output logic [15:0] g);
		logic [15:0] r [3];
		int n;
		for (int i = 0; i < 3; i++) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while ((t3 ? cap3 : cap2) !== 1'b1 && n < 800);
			if (pol) chk(16'(lf), 16'(t3));
			chk((t3 ? cnt3 : cnt2) - (t3 ? rl3 : rl2), 16'h1);
			@(negedge clk);
			r[i] = t3 ? rl3 : rl2;
		end
		g = r[2] - r[1];
	endtask : cap_gap
	task automatic t_lf();
		logic [15:0] per [4] = '{16'h140, 16'ha0, 16'h50, 16'h28};
		logic [15:0] g;
		// edges arrive but neither timer is in capture mode yet
		wr_reg(8'he3, 8'hbf);
		repeat (110) @(negedge clk);
		chk(rl2, 16'h0);
		chk(rl3, 16'h0);
		rd_reg(8'he3, 8'hff);
		// low-frequency source: one tick per undivided period
		wr_reg(8'ha9, 8'h02);
		period(g);
		chk(g, per[3]);
		wr_reg(8'ha9, 8'h00);
		lf_on = 1'b1;
		for (int d = 3; d >= 0; d--) begin
			wr_reg(8'he3, 8'hbc | 8'(d));
			chk(16'(trim), 16'hf);
			chk(16'(lfen), 16'h1);
			cap_gap(1'b1, d == 3, g);
			chk(g, per[d]);
			cap_gap(1'b0, d == 3, g);
			chk(g, per[d]);
		end
		lf_on = 1'b0;
	endtask : t_lf
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_hfdiv();
		t_enable();
		t_suspend();
		t_lf();
		give_verdict();
	end
endmodule : tb_top
bind olc_osc_ctrl olc_osc_ctrl_sva #(.TMR_W(TMR_W), .WAKE_W(WAKE_W)) u_sva (
	.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
	.SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
	.SFR_WDATA_I(SFR_WDATA_I), .SFR_RDATA_O(SFR_RDATA_O),
	.WAKE_EVENT_I(WAKE_EVENT_I), .WAKE_TMR_TICK_I(WAKE_TMR_TICK_I),
	.HF_OSC_RUN_O(HF_OSC_RUN_O), .LF_FREQ_TRIM_O(LF_FREQ_TRIM_O),
	.WAKE_TIMER_SYNC_BUSY_O(WAKE_TIMER_SYNC_BUSY_O),
	.TMR2_LFCAP_MODE_I(TMR2_LFCAP_MODE_I),
	.TMR3_LFCAP_MODE_I(TMR3_LFCAP_MODE_I), .TMR2_RELOAD_O(TMR2_RELOAD_O),
	.TMR2_CAPTURE_O(TMR2_CAPTURE_O), .TMR3_CAPTURE_O(TMR3_CAPTURE_O));
